// *** dct_pkg.sv ***
// Package: register map, field layout, reset values and types of the channel timing block
package dct_pkg;

  // Register byte offsets within the controller hub window
  localparam logic [11:0] OFS_WRITE_SPACING   = 12'h0256;
  localparam logic [11:0] OFS_READ_SPACING    = 12'h0258;
  localparam logic [11:0] OFS_REFRESH_SPACING = 12'h025B;
  localparam logic [11:0] OFS_CKE_CONTROL     = 12'h0260;

  // Register sizes in bytes and their byte index in the flat image
  localparam logic [3:0] WR_BYTES  = 4'h2;
  localparam logic [3:0] RD_BYTES  = 4'h3;
  localparam logic [3:0] REF_BYTES = 4'h2;
  localparam logic [3:0] CKE_BYTES = 4'h4;
  localparam logic [3:0] WR_IDX    = 4'h0;
  localparam logic [3:0] RD_IDX    = 4'h2;
  localparam logic [3:0] REF_IDX   = 4'h5;
  localparam logic [3:0] CKE_IDX   = 4'h7;
  localparam logic [3:0] NO_IDX    = 4'hF;
  localparam int         CFG_W     = 88;

  // Bit base of each register in the flat image
  localparam int WR_BASE  = 0;
  localparam int RD_BASE  = 16;
  localparam int REF_BASE = 40;
  localparam int CKE_BASE = 56;

  // Field positions within each register
  localparam int ACT_WR_LSB      = 12;
  localparam int WW_SAME_LSB     = 8;
  localparam int WW_DIFF_LSB     = 4;
  localparam int RD_WR_LSB       = 0;
  localparam int ACT_RD_LSB      = 17;
  localparam int WR_SAME_LSB     = 12;
  localparam int WR_DIFF_LSB     = 8;
  localparam int RR_SAME_LSB     = 4;
  localparam int RR_DIFF_LSB     = 0;
  localparam int PREALL_REF_LSB  = 9;
  localparam int REF_REF_LSB     = 0;
  localparam int SR_EXIT_REQ_BIT = 27;
  localparam int CKE_HIGH_LSB    = 24;
  localparam int RANK_PRES_LSB   = 20;
  localparam int CKE_LOW_LSB     = 17;
  localparam int PD_TOGGLE_BIT   = 16;
  localparam int PD_EXIT_LSB     = 10;
  localparam int SR_EXIT_CNT_LSB = 1;
  localparam int SINGLE_MOD_BIT  = 0;

  // Reset values
  localparam logic [15:0] RST_WRITE_SPACING   = 16'h0000;
  localparam logic [23:0] RST_READ_SPACING    = 24'h00_0000;
  localparam logic [15:0] RST_REFRESH_SPACING = 16'h0000;
  localparam logic [31:0] RST_CKE_CONTROL     = 32'h0000_0800;
  localparam logic [CFG_W-1:0] CFG_RESET = {RST_CKE_CONTROL, RST_REFRESH_SPACING,
                                            RST_READ_SPACING, RST_WRITE_SPACING};

  // Writable bits; reserved bits stay zero
  localparam logic [CFG_W-1:0] CFG_WMASK = {32'h0FFF_3FFF, 16'h1FFF, 24'h1F_FFFF, 16'hFFFF};
  // Rank population bits, frozen by the stolen-memory lock
  localparam logic [CFG_W-1:0] CFG_LOCK_MASK = {32'h00F0_0000, 56'h00_0000_0000_0000};

  // Power-down exit code range
  localparam logic [3:0] PD_EXIT_MIN = 4'h2;
  localparam logic [3:0] PD_EXIT_MAX = 4'h9;

  // Elapsed-clock counters
  localparam logic [8:0] EL_MAX = 9'h1FF;
  localparam logic [8:0] EL_ONE = 9'h001;

  typedef enum logic [2:0] {CMD_ACT, CMD_READ, CMD_WRITE, CMD_PREALL, CMD_REF} dct_cmd_e;
  typedef enum logic [1:0] {CKE_ON, CKE_PD, CKE_SR} dct_cke_e;

endpackage

// *** dct_channel_timing.sv ***
// Channel 0 command spacing and clock-enable control with its registers
module dct_channel_timing (
  input  logic              sys_clk,
  input  logic              srst,
  input  logic [11:0]       regAddr,
  input  logic              regWr,
  input  logic              regRd,
  input  logic [7:0]        regWrData,
  input  logic              stolenLock,
  output logic [7:0]        regRdData,
  output logic              regRdValid,
  input  logic              dram_clk,
  input  logic              cmdValid,
  input  dct_pkg::dct_cmd_e cmdType,
  input  logic [1:0]        cmdRank,
  input  logic [2:0]        cmdBank,
  input  logic              pdReq,
  input  logic              srEnterReq,
  output logic              cke,
  output logic              cmdIssue,
  output dct_pkg::dct_cmd_e cmdIssueType,
  output logic [1:0]        cmdIssueRank,
  output logic [2:0]        cmdIssueBank
);

  typedef struct packed {
    logic                     lockS1;
    logic                     lockS2;
    logic [dct_pkg::CFG_W-1:0] cfg;
    logic [dct_pkg::CFG_W-1:0] snap;
    logic                     reqTgl;
    logic                     ackS1;
    logic                     ackS2;
    logic [7:0]               rdData;
    logic                     rdValid;
  } dct_sys_s;

  typedef struct packed {
    logic                     rs1;
    logic                     rs2;
    logic                     reqS1;
    logic                     reqS2;
    logic                     ackTgl;
    logic [dct_pkg::CFG_W-1:0] cfg;
    logic                     srReqPrev;
    logic                     srPend;
    dct_pkg::dct_cke_e        ckeSt;
    logic                     cke;
    logic [8:0]               ckeCnt;
    logic [8:0]               txpCnt;
    logic [8:0]               srxCnt;
    logic [31:0][8:0]         actEl;
    logic [3:0][8:0]          wrEl;
    logic [3:0][8:0]          rdEl;
    logic [3:0][8:0]          preallEl;
    logic [3:0][8:0]          refEl;
    logic                     issue;
    dct_pkg::dct_cmd_e        issType;
    logic [1:0]               issRank;
    logic [2:0]               issBank;
  } dct_dram_s;

  dct_sys_s  sq_r;
  dct_sys_s  sq_nxt;
  dct_dram_s dq_r;
  dct_dram_s dq_nxt;

  // Map a byte address to its index in the flat register image
  function automatic logic [3:0] cfgIndex(input logic [11:0] a);
    logic [11:0] d;
    d = 12'h000;
    if (a >= dct_pkg::OFS_WRITE_SPACING && a < dct_pkg::OFS_WRITE_SPACING + 12'(dct_pkg::WR_BYTES)) begin
      d = a - dct_pkg::OFS_WRITE_SPACING;
      return dct_pkg::WR_IDX + d[3:0];
    end
    if (a >= dct_pkg::OFS_READ_SPACING && a < dct_pkg::OFS_READ_SPACING + 12'(dct_pkg::RD_BYTES)) begin
      d = a - dct_pkg::OFS_READ_SPACING;
      return dct_pkg::RD_IDX + d[3:0];
    end
    if (a >= dct_pkg::OFS_REFRESH_SPACING && a < dct_pkg::OFS_REFRESH_SPACING + 12'(dct_pkg::REF_BYTES)) begin
      d = a - dct_pkg::OFS_REFRESH_SPACING;
      return dct_pkg::REF_IDX + d[3:0];
    end
    if (a >= dct_pkg::OFS_CKE_CONTROL && a < dct_pkg::OFS_CKE_CONTROL + 12'(dct_pkg::CKE_BYTES)) begin
      d = a - dct_pkg::OFS_CKE_CONTROL;
      return dct_pkg::CKE_IDX + d[3:0];
    end
    return dct_pkg::NO_IDX;
  endfunction

  function automatic logic [8:0] satInc(input logic [8:0] v);
    return (v == dct_pkg::EL_MAX) ? v : v + dct_pkg::EL_ONE;
  endfunction

  function automatic logic gapOk(input logic [8:0] el, input logic [8:0] gap);
    return el >= gap;
  endfunction

  // Reserved exit codes are clamped into the legal 2..9 range
  function automatic logic [8:0] txpClocks(input logic [3:0] code);
    if (code < dct_pkg::PD_EXIT_MIN) return {5'h00, dct_pkg::PD_EXIT_MIN};
    if (code > dct_pkg::PD_EXIT_MAX) return {5'h00, dct_pkg::PD_EXIT_MAX};
    return {5'h00, code};
  endfunction

  // ---------------- Register side, sys_clk ----------------
  logic [3:0] wrIdx;
  logic [7:0] wrMask;

  always_comb begin
    sq_nxt         = sq_r;
    sq_nxt.lockS1  = stolenLock;
    sq_nxt.lockS2  = sq_r.lockS1;
    sq_nxt.ackS1   = dq_r.ackTgl;
    sq_nxt.ackS2   = sq_r.ackS1;
    sq_nxt.rdValid = 1'b0;
    wrIdx          = cfgIndex(regAddr);
    wrMask         = dct_pkg::CFG_WMASK[{wrIdx, 3'b000} +: 8];
    if (sq_r.lockS2) begin
      wrMask = wrMask & ~dct_pkg::CFG_LOCK_MASK[{wrIdx, 3'b000} +: 8];
    end
    if (regWr && wrIdx != dct_pkg::NO_IDX) begin
      sq_nxt.cfg[{wrIdx, 3'b000} +: 8] = (sq_r.cfg[{wrIdx, 3'b000} +: 8] & ~wrMask) | (regWrData & wrMask);
    end
    if (regRd) begin
      sq_nxt.rdValid = 1'b1;
      sq_nxt.rdData  = (wrIdx == dct_pkg::NO_IDX) ? 8'h00 : sq_r.cfg[{wrIdx, 3'b000} +: 8];
    end
    // Snapshot only moves while no handshake is open, so the far side reads a stable word
    if (sq_r.reqTgl == sq_r.ackS2 && sq_r.snap != sq_r.cfg) begin
      sq_nxt.snap   = sq_r.cfg;
      sq_nxt.reqTgl = ~sq_r.reqTgl;
    end
    if (srst) begin
      sq_nxt      = '0;
      sq_nxt.cfg  = dct_pkg::CFG_RESET;
      sq_nxt.snap = dct_pkg::CFG_RESET;
    end
  end

  always_ff @(posedge sys_clk) begin
    sq_r <= sq_nxt;
  end

  assign regRdData  = sq_r.rdData;
  assign regRdValid = sq_r.rdValid;

  // ---------------- DRAM side, dram_clk ----------------
  logic [15:0] wrReg;
  logic [23:0] rdReg;
  logic [15:0] refReg;
  logic [31:0] ckeReg;
  logic [8:0]  actWrGap, wwSameGap, wwDiffGap, rdWrGap, actRdGap, wrSameGap, wrDiffGap;
  logic [8:0]  rrSameGap, rrDiffGap, preallRefGap, refRefGap, srExitGap, txpGap;
  logic [2:0]  ckeHighW, ckeLowW;
  logic [3:0]  rankPresent;
  logic        pdToggleEn, singleMod, srExitBit;
  logic [4:0]  rb;
  logic        rankOk, cmdOk, allow, accept;

  assign wrReg       = dq_r.cfg[dct_pkg::WR_BASE +: 16];
  assign rdReg       = dq_r.cfg[dct_pkg::RD_BASE +: 24];
  assign refReg      = dq_r.cfg[dct_pkg::REF_BASE +: 16];
  assign ckeReg      = dq_r.cfg[dct_pkg::CKE_BASE +: 32];
  assign actWrGap    = {5'h00, wrReg[dct_pkg::ACT_WR_LSB +: 4]};
  assign wwSameGap   = {5'h00, wrReg[dct_pkg::WW_SAME_LSB +: 4]};
  assign wwDiffGap   = {5'h00, wrReg[dct_pkg::WW_DIFF_LSB +: 4]};
  assign rdWrGap     = {5'h00, wrReg[dct_pkg::RD_WR_LSB +: 4]};
  assign actRdGap    = {5'h00, rdReg[dct_pkg::ACT_RD_LSB +: 4]};
  assign wrSameGap   = {4'h0, rdReg[dct_pkg::WR_SAME_LSB +: 5]};
  assign wrDiffGap   = {5'h00, rdReg[dct_pkg::WR_DIFF_LSB +: 4]};
  assign rrSameGap   = {5'h00, rdReg[dct_pkg::RR_SAME_LSB +: 4]};
  assign rrDiffGap   = {5'h00, rdReg[dct_pkg::RR_DIFF_LSB +: 4]};
  assign preallRefGap = {5'h00, refReg[dct_pkg::PREALL_REF_LSB +: 4]};
  assign refRefGap   = refReg[dct_pkg::REF_REF_LSB +: 9];
  assign srExitBit   = ckeReg[dct_pkg::SR_EXIT_REQ_BIT];
  assign ckeHighW    = ckeReg[dct_pkg::CKE_HIGH_LSB +: 3];
  assign rankPresent = ckeReg[dct_pkg::RANK_PRES_LSB +: 4];
  assign ckeLowW     = ckeReg[dct_pkg::CKE_LOW_LSB +: 3];
  assign pdToggleEn  = ckeReg[dct_pkg::PD_TOGGLE_BIT];
  assign txpGap      = txpClocks(ckeReg[dct_pkg::PD_EXIT_LSB +: 4]);
  assign srExitGap   = ckeReg[dct_pkg::SR_EXIT_CNT_LSB +: 9];
  assign singleMod   = ckeReg[dct_pkg::SINGLE_MOD_BIT];
  assign rb          = {cmdRank, cmdBank};

  // Issue check
  always_comb begin
    rankOk = rankPresent[cmdRank] && !(singleMod && cmdRank[1]);
    cmdOk  = 1'b1;
    unique case (cmdType)
      dct_pkg::CMD_ACT: begin
        cmdOk = gapOk(dq_r.txpCnt, txpGap);
      end
      dct_pkg::CMD_WRITE: begin
        cmdOk = gapOk(dq_r.txpCnt, txpGap) && gapOk(dq_r.actEl[rb], actWrGap)
                && gapOk(dq_r.wrEl[cmdRank], wwSameGap);
        for (int j = 0; j < 4; j++) begin
          if (2'(j) != cmdRank && !gapOk(dq_r.wrEl[j], wwDiffGap)) cmdOk = 1'b0;
          if (!gapOk(dq_r.rdEl[j], rdWrGap)) cmdOk = 1'b0;
        end
      end
      dct_pkg::CMD_READ: begin
        // Reads are exempt from the power-down exit gap
        cmdOk = gapOk(dq_r.actEl[rb], actRdGap)
                && gapOk(dq_r.wrEl[cmdRank], wrSameGap)
                && gapOk(dq_r.rdEl[cmdRank], rrSameGap);
        for (int j = 0; j < 4; j++) begin
          if (2'(j) != cmdRank && !gapOk(dq_r.wrEl[j], wrDiffGap)) cmdOk = 1'b0;
          if (2'(j) != cmdRank && !gapOk(dq_r.rdEl[j], rrDiffGap)) cmdOk = 1'b0;
        end
      end
      dct_pkg::CMD_PREALL: begin
        cmdOk = gapOk(dq_r.txpCnt, txpGap);
      end
      dct_pkg::CMD_REF: begin
        cmdOk = gapOk(dq_r.txpCnt, txpGap) && gapOk(dq_r.preallEl[cmdRank], preallRefGap)
                && gapOk(dq_r.refEl[cmdRank], refRefGap);
      end
      default: cmdOk = 1'b0;
    endcase
    // One command per two clocks: the scheduler drops valid after seeing cmdIssue
    allow  = rankOk && cmdOk && dq_r.ckeSt == dct_pkg::CKE_ON && dq_r.cke && !dq_r.issue
             && gapOk(dq_r.srxCnt, srExitGap);
    accept = cmdValid && allow;
  end

  always_comb begin
    dq_nxt       = dq_r;
    dq_nxt.rs1   = srst;
    dq_nxt.rs2   = dq_r.rs1;
    dq_nxt.reqS1 = sq_r.reqTgl;
    dq_nxt.reqS2 = dq_r.reqS1;
    if (dq_r.reqS2 != dq_r.ackTgl) begin
      dq_nxt.cfg    = sq_r.snap;
      dq_nxt.ackTgl = dq_r.reqS2;
    end
    for (int i = 0; i < 32; i++) dq_nxt.actEl[i] = satInc(dq_r.actEl[i]);
    for (int i = 0; i < 4; i++) begin
      dq_nxt.wrEl[i]   = satInc(dq_r.wrEl[i]);
      dq_nxt.rdEl[i]   = satInc(dq_r.rdEl[i]);
      dq_nxt.preallEl[i] = satInc(dq_r.preallEl[i]);
      dq_nxt.refEl[i]  = satInc(dq_r.refEl[i]);
    end
    dq_nxt.issue = accept;
    if (accept) begin
      dq_nxt.issType = cmdType;
      dq_nxt.issRank = cmdRank;
      dq_nxt.issBank = cmdBank;
      unique case (cmdType)
        dct_pkg::CMD_ACT:    dq_nxt.actEl[rb]        = dct_pkg::EL_ONE;
        dct_pkg::CMD_WRITE:  dq_nxt.wrEl[cmdRank]    = dct_pkg::EL_ONE;
        dct_pkg::CMD_READ:   dq_nxt.rdEl[cmdRank]    = dct_pkg::EL_ONE;
        dct_pkg::CMD_PREALL: dq_nxt.preallEl[cmdRank] = dct_pkg::EL_ONE;
        dct_pkg::CMD_REF:    dq_nxt.refEl[cmdRank]   = dct_pkg::EL_ONE;
        default: ;
      endcase
    end
    dq_nxt.ckeCnt    = satInc(dq_r.ckeCnt);
    dq_nxt.txpCnt    = satInc(dq_r.txpCnt);
    dq_nxt.srxCnt    = satInc(dq_r.srxCnt);
    dq_nxt.srReqPrev = srExitBit;
    if (srExitBit && !dq_r.srReqPrev && dq_r.ckeSt == dct_pkg::CKE_SR) begin
      dq_nxt.srPend = 1'b1;
    end
    unique case (dq_r.ckeSt)
      dct_pkg::CKE_ON: begin
        // Entry waits for an idle command slot so no command rides the falling edge
        if (!cmdValid && !dq_r.issue && gapOk(dq_r.ckeCnt, {6'h00, ckeHighW})) begin
          if (srEnterReq) begin
            dq_nxt.ckeSt  = dct_pkg::CKE_SR;
            dq_nxt.cke    = 1'b0;
            dq_nxt.ckeCnt = dct_pkg::EL_ONE;
          end else if (pdReq && pdToggleEn) begin
            dq_nxt.ckeSt  = dct_pkg::CKE_PD;
            dq_nxt.cke    = 1'b0;
            dq_nxt.ckeCnt = dct_pkg::EL_ONE;
          end
        end
      end
      dct_pkg::CKE_PD: begin
        // Exit also needs the enable; clearing it parks the rank low until re-enabled
        if (!pdReq && pdToggleEn && gapOk(dq_r.ckeCnt, {6'h00, ckeLowW})) begin
          dq_nxt.ckeSt  = dct_pkg::CKE_ON;
          dq_nxt.cke    = 1'b1;
          dq_nxt.ckeCnt = dct_pkg::EL_ONE;
          dq_nxt.txpCnt = dct_pkg::EL_ONE;
        end
      end
      dct_pkg::CKE_SR: begin
        if (dq_r.srPend && gapOk(dq_r.ckeCnt, {6'h00, ckeLowW})) begin
          dq_nxt.ckeSt  = dct_pkg::CKE_ON;
          dq_nxt.cke    = 1'b1;
          dq_nxt.srPend = 1'b0;
          dq_nxt.ckeCnt = dct_pkg::EL_ONE;
          dq_nxt.srxCnt = dct_pkg::EL_ONE;
        end
      end
      default: dq_nxt.ckeSt = dct_pkg::CKE_ON;
    endcase
    if (dq_r.rs2) begin
      dq_nxt        = '0;
      dq_nxt.rs1    = srst;
      dq_nxt.rs2    = dq_r.rs1;
      dq_nxt.reqS1  = sq_r.reqTgl;
      dq_nxt.reqS2  = dq_r.reqS1;
      dq_nxt.cfg    = dct_pkg::CFG_RESET;
      dq_nxt.ckeSt  = dct_pkg::CKE_ON;
      dq_nxt.cke    = 1'b1;
      dq_nxt.ckeCnt = dct_pkg::EL_MAX;
      dq_nxt.txpCnt = dct_pkg::EL_MAX;
      dq_nxt.srxCnt = dct_pkg::EL_MAX;
      dq_nxt.actEl  = {32{dct_pkg::EL_MAX}};
      dq_nxt.wrEl   = {4{dct_pkg::EL_MAX}};
      dq_nxt.rdEl   = {4{dct_pkg::EL_MAX}};
      dq_nxt.preallEl = {4{dct_pkg::EL_MAX}};
      dq_nxt.refEl  = {4{dct_pkg::EL_MAX}};
    end
  end

  always_ff @(posedge dram_clk) begin
    dq_r <= dq_nxt;
  end

  assign cke          = dq_r.cke;
  assign cmdIssue     = dq_r.issue;
  assign cmdIssueType = dq_r.issType;
  assign cmdIssueRank = dq_r.issRank;
  assign cmdIssueBank = dq_r.issBank;

  // ---------------- Checks ----------------
  logic issWr, issRd, issRef;
  assign issWr  = dq_r.issue && dq_r.issType == dct_pkg::CMD_WRITE;
  assign issRd  = dq_r.issue && dq_r.issType == dct_pkg::CMD_READ;
  assign issRef = dq_r.issue && dq_r.issType == dct_pkg::CMD_REF;

  property p_act_wr;
    @(posedge dram_clk) disable iff (dq_r.rs2)
    issWr |-> $past(dq_r.actEl[rb]) >= $past(actWrGap);
  endproperty
  a_act_wr: assert property (p_act_wr) else $error("write too soon after activate");

  property p_wr_wr_same;
    @(posedge dram_clk) disable iff (dq_r.rs2)
    issWr |-> $past(dq_r.wrEl[cmdRank]) >= $past(wwSameGap);
  endproperty
  a_wr_wr_same: assert property (p_wr_wr_same) else $error("same-rank writes too close");

  property p_wr_rd_same;
    @(posedge dram_clk) disable iff (dq_r.rs2)
    issRd |-> $past(dq_r.wrEl[cmdRank]) >= $past(wrSameGap);
  endproperty
  a_wr_rd_same: assert property (p_wr_rd_same) else $error("read too soon after same-rank write");

  property p_ref_ref;
    @(posedge dram_clk) disable iff (dq_r.rs2)
    issRef |-> $past(dq_r.refEl[cmdRank]) >= $past(refRefGap)
               && $past(dq_r.preallEl[cmdRank]) >= $past(preallRefGap);
  endproperty
  a_ref_ref: assert property (p_ref_ref) else $error("refresh spacing violated");

  property p_cke_high;
    @(posedge dram_clk) disable iff (dq_r.rs2)
    $fell(dq_r.cke) |-> $past(dq_r.ckeCnt) >= {6'h00, $past(ckeHighW)};
  endproperty
  a_cke_high: assert property (p_cke_high) else $error("clock enable high phase too short");

  property p_cke_low;
    @(posedge dram_clk) disable iff (dq_r.rs2)
    $rose(dq_r.cke) |-> $past(dq_r.ckeCnt) >= {6'h00, $past(ckeLowW)};
  endproperty
  a_cke_low: assert property (p_cke_low) else $error("clock enable low phase too short");

  property p_pd_toggle;
    @(posedge dram_clk) disable iff (dq_r.rs2)
    $fell(dq_r.cke) && dq_r.ckeSt == dct_pkg::CKE_PD |-> $past(pdToggleEn);
  endproperty
  a_pd_toggle: assert property (p_pd_toggle) else $error("power-down toggle while disabled");

  property p_txp;
    @(posedge dram_clk) disable iff (dq_r.rs2)
    $rose(dq_r.cke) && dq_r.txpCnt == dct_pkg::EL_ONE |-> ##1 !(dq_r.issue && dq_r.issType != dct_pkg::CMD_READ);
  endproperty
  a_txp: assert property (p_txp) else $error("command right after clock enable rise");

  sequence s_sr_ready;
    dq_r.ckeSt == dct_pkg::CKE_SR && dq_r.srPend && gapOk(dq_r.ckeCnt, {6'h00, ckeLowW});
  endsequence
  sequence s_sr_exit;
    ##1 (dq_r.cke && dq_r.ckeSt == dct_pkg::CKE_ON && dq_r.srxCnt == dct_pkg::EL_ONE);
  endsequence
  property p_sr_exit;
    @(posedge dram_clk) disable iff (dq_r.rs2)
    s_sr_ready |-> s_sr_exit;
  endproperty
  a_sr_exit: assert property (p_sr_exit) else $error("self-refresh exit not started");

  property p_one_per_two;
    @(posedge dram_clk) disable iff (dq_r.rs2)
    dq_r.issue |=> !dq_r.issue;
  endproperty
  a_one_per_two: assert property (p_one_per_two) else $error("back-to-back command issue");

  property p_lock;
    @(posedge sys_clk) disable iff (srst)
    sq_r.lockS2 |=> (sq_r.cfg & dct_pkg::CFG_LOCK_MASK) == $past(sq_r.cfg & dct_pkg::CFG_LOCK_MASK);
  endproperty
  a_lock: assert property (p_lock) else $error("locked rank bits changed");

endmodule // dct_channel_timing

// *** dct_dram_model.sv ***
// Memory rank model: counts issued commands, flags any sent with clock enable low
module dct_dram_model (
  input  logic dram_clk,
  input  logic cke,
  input  logic cmdIssue,
  output int   cmdCount,
  output int   badCount
);
  timeunit 1ns;
  timeprecision 100ps;
  int cmds = 0;
  int bads = 0;
  assign cmdCount = cmds;
  assign badCount = bads;
  // Ranks in power-down or self-refresh would drop a command
  always @(posedge dram_clk) begin
    if (cmdIssue === 1'b1) begin
      cmds <= cmds + 1;
      bads <= bads + ((cke !== 1'b1) ? 1 : 0);
    end
  end
endmodule // dct_dram_model

// *** tb.sv ***
// Bench: register, command spacing and clock enable checks
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0, dram_clk = 1'b0, srst = 1'b1, regWr = 1'b0, regRd = 1'b0, stolenLock = 1'b0;
  logic cmdValid = 1'b0, pdReq = 1'b0, srEnterReq = 1'b0, regRdValid, cke, cmdIssue;
  logic [11:0] regAddr = 12'h000;
  logic [7:0] regWrData = 8'h00, regRdData;
  logic [1:0] cmdRank = 2'h0, cmdIssueRank;
  logic [2:0] cmdBank = 3'h0, cmdIssueBank;
  dct_pkg::dct_cmd_e cmdType = dct_pkg::CMD_ACT, cmdIssueType;
  int num_errors = 0, checks_done = 0, dcyc = 0, cmdCount, badCount, t[14];
  // Address low byte and data for the spacing setup
  logic [15:0] cfg[8] = '{16'h5634, 16'h5756, 16'h5863, 16'h5975, 16'h5A08, 16'h5B09, 16'h5C0A, 16'h6230};
  always #4 sys_clk = ~sys_clk;
  always #3 dram_clk = ~dram_clk;
  always @(posedge dram_clk) dcyc <= dcyc + 1;
  dct_channel_timing dut (.sys_clk(sys_clk), .srst(srst), .regAddr(regAddr), .regWr(regWr), .regRd(regRd),
    .regWrData(regWrData), .stolenLock(stolenLock), .regRdData(regRdData), .regRdValid(regRdValid),
    .dram_clk(dram_clk), .cmdValid(cmdValid), .cmdType(cmdType), .cmdRank(cmdRank), .cmdBank(cmdBank),
    .pdReq(pdReq), .srEnterReq(srEnterReq), .cke(cke), .cmdIssue(cmdIssue), .cmdIssueType(cmdIssueType),
    .cmdIssueRank(cmdIssueRank), .cmdIssueBank(cmdIssueBank));
  dct_dram_model partner (.dram_clk(dram_clk), .cke(cke), .cmdIssue(cmdIssue), .cmdCount(cmdCount),
    .badCount(badCount));
  task automatic chkV(string name, logic [31:0] exp, logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
    end
  endtask
  task automatic chkM(string name, int minGap, int got);
    checks_done++;
    if (got < minGap) begin
      num_errors++;
      $display("[FAIL] %s expected >= %0d seen %0d", name, minGap, got);
    end
  endtask
  task automatic regW(logic [11:0] a, logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask
  task automatic regR(logic [11:0] a, logic [7:0] exp);
    @(posedge sys_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    @(posedge sys_clk);
    chkV("register byte", {1'b1, exp}, {regRdValid, regRdData});
  endtask
  // Holds the request until the issue pulse is seen, then drops it
  task automatic cmd(dct_pkg::dct_cmd_e ty, logic [1:0] rk, int tRef, int minGap, output int tIss);
    int n;
    n = 0;
    @(posedge dram_clk);
    cmdType <= ty;
    cmdRank <= rk;
    cmdValid <= 1'b1;
    do begin
      @(posedge dram_clk);
      n++;
    end while (cmdIssue !== 1'b1 && n < 600);
    tIss = dcyc;
    cmdValid <= 1'b0;
    chkV("issued command", {1'b1, ty, rk, cmdBank}, {cmdIssue, cmdIssueType, cmdIssueRank, cmdIssueBank});
    chkM("command spacing", minGap, tIss - tRef);
  endtask
  task automatic waitCke(logic lvl, output int tCh);
    int n;
    n = 0;
    do begin
      @(posedge dram_clk);
      n++;
    end while (cke !== lvl && n < 400);
    tCh = dcyc;
    chkV("clock enable", lvl, cke);
  endtask
  task automatic testRegs;
    regR(12'h0261, 8'h08);
    regR(12'h025D, 8'h00);
    regW(12'h025A, 8'hFF);
    regR(12'h025A, 8'h1F);
    stolenLock <= 1'b1;
    repeat (4) @(posedge sys_clk);
    regW(12'h0262, 8'hF0);
    regR(12'h0262, 8'h00);
    stolenLock <= 1'b0;
    repeat (4) @(posedge sys_clk);
    regW(12'h0262, 8'hF0);
    regR(12'h0262, 8'hF0);
    $display("register test done");
  endtask
  task automatic testSpacing;
    foreach (cfg[i]) regW({4'h2, cfg[i][15:8]}, cfg[i][7:0]);
    repeat (20) @(posedge dram_clk);
    cmd(dct_pkg::CMD_ACT, 2'h0, 0, 0, t[0]);
    cmd(dct_pkg::CMD_WRITE, 2'h0, t[0], 5, t[1]);
    cmd(dct_pkg::CMD_WRITE, 2'h0, t[1], 6, t[2]);
    cmd(dct_pkg::CMD_WRITE, 2'h1, t[2], 3, t[3]);
    cmd(dct_pkg::CMD_READ, 2'h0, t[3], 5, t[4]);
    cmd(dct_pkg::CMD_READ, 2'h0, t[4], 6, t[5]);
    cmd(dct_pkg::CMD_READ, 2'h1, t[5], 3, t[6]);
    cmd(dct_pkg::CMD_WRITE, 2'h1, t[6], 4, t[7]);
    cmd(dct_pkg::CMD_READ, 2'h1, t[7], 7, t[8]);
    // Second bank: activate then read on rank 0 bank 1 checks the activate-to-read gap
    cmdBank <= 3'h1;
    cmd(dct_pkg::CMD_ACT, 2'h0, 0, 0, t[9]);
    cmd(dct_pkg::CMD_READ, 2'h0, t[9], 4, t[10]);
    cmd(dct_pkg::CMD_PREALL, 2'h0, 0, 0, t[11]);
    cmd(dct_pkg::CMD_REF, 2'h0, t[11], 5, t[12]);
    cmd(dct_pkg::CMD_REF, 2'h0, t[12], 9, t[13]);
    $display("spacing test done");
  endtask
  task automatic testCke;
    regW(12'h0261, 8'h14);
    regW(12'h0262, 8'h37);
    regW(12'h0263, 8'h07);
    repeat (20) @(posedge dram_clk);
    pdReq <= 1'b1;
    waitCke(1'b0, t[0]);
    pdReq <= 1'b0;
    waitCke(1'b1, t[1]);
    chkM("low width", 3, t[1] - t[0]);
    cmd(dct_pkg::CMD_WRITE, 2'h0, t[1], 5, t[2]);
    pdReq <= 1'b1;
    waitCke(1'b0, t[3]);
    chkM("high width", 7, t[3] - t[1]);
    pdReq <= 1'b0;
    waitCke(1'b1, t[4]);
    $display("clock enable test done");
  endtask
  task automatic testSelfRefresh;
    regW(12'h0260, 8'h14);
    repeat (20) @(posedge dram_clk);
    srEnterReq <= 1'b1;
    waitCke(1'b0, t[0]);
    srEnterReq <= 1'b0;
    repeat (30) @(posedge dram_clk);
    chkV("held in self refresh", 32'h0, cke);
    regW(12'h0263, 8'h0F);
    waitCke(1'b1, t[1]);
    cmd(dct_pkg::CMD_READ, 2'h0, t[1], 10, t[2]);
    $display("self refresh test done");
  endtask
  task automatic testSingle;
    regW(12'h0262, 8'hF7);
    regW(12'h0260, 8'h15);
    repeat (20) @(posedge dram_clk);
    cmdType <= dct_pkg::CMD_ACT;
    cmdRank <= 2'h2;
    cmdValid <= 1'b1;
    repeat (30) @(posedge dram_clk);
    cmdValid <= 1'b0;
    chkV("single module rank 2 blocked", 32'd16, cmdCount);
    $display("single module test done");
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    repeat (4) @(posedge dram_clk);
    testRegs;
    testSpacing;
    testCke;
    testSelfRefresh;
    testSingle;
    chkV("partner bad commands", 32'h0, badCount);
    end_of_test;
  end
  initial begin
    #100000;
    num_errors++;
    end_of_test;
  end
endmodule // tb
